// ### rtl/tmrwc_pkg.sv
/*
  Shared constants for the 8-bit timer waveform compare control block:
  register offsets, field positions, reset values, mode and code values.
  Assumes an 8-bit register port and a single clock domain.
*/
package tmrwc_pkg;
  // Register port widths.
  localparam int unsigned AW = 8;
  localparam int unsigned DW = 8;
  // Register offsets.
  localparam logic [7:0] ADDR_CTRL_A = 8'h24;
  localparam logic [7:0] ADDR_CTRL_B = 8'h25;
  localparam logic [7:0] ADDR_COUNT = 8'h26;
  localparam logic [7:0] ADDR_CMP_A = 8'h27;
  localparam logic [7:0] ADDR_CMP_B = 8'h28;
  localparam logic [7:0] ADDR_FLAGS = 8'h29;
  // Field positions of control register A.
  localparam int CA_COMA_LSB = 6;
  localparam int CA_COMB_LSB = 4;
  localparam int CA_WGM_LSB = 0;
  // Field positions of control register B.
  localparam int CB_FOCA_BIT = 7;
  localparam int CB_FOCB_BIT = 6;
  localparam int CB_WGM2_BIT = 3;
  localparam int CB_CS_LSB = 0;
  // Flag bit positions.
  localparam int FL_TOV_BIT = 0;
  localparam int FL_MA_BIT = 1;
  localparam int FL_MB_BIT = 2;
  // Reset values.
  localparam logic [7:0] CTRL_A_RST = 8'h00;
  localparam logic [7:0] CTRL_B_RST = 8'h00;
  localparam logic [7:0] CNT_RST = 8'h00;
  localparam logic [7:0] CMP_RST = 8'h00;
  localparam logic [2:0] FLAGS_RST = 3'h0;
  // Counter extremes.
  localparam logic [7:0] MAX_VAL = 8'hff;
  localparam logic [7:0] BOTTOM_VAL = 8'h00;
  // Compare output mode codes.
  localparam logic [1:0] COM_OFF = 2'h0;
  localparam logic [1:0] COM_TOGGLE = 2'h1;
  localparam logic [1:0] COM_CLEAR = 2'h2;
  localparam logic [1:0] COM_SET = 2'h3;
  // Waveform mode numbers.
  localparam logic [2:0] WGM_NORMAL = 3'h0;
  localparam logic [2:0] WGM_PHASE_FF = 3'h1;
  localparam logic [2:0] WGM_CTC = 3'h2;
  localparam logic [2:0] WGM_FAST_FF = 3'h3;
  localparam logic [2:0] WGM_PHASE_CA = 3'h5;
  localparam logic [2:0] WGM_FAST_CA = 3'h7;
  // Clock select codes and prescaler masks.
  localparam logic [2:0] CS_STOP = 3'h0;
  localparam logic [2:0] CS_DIV1 = 3'h1;
  localparam logic [2:0] CS_DIV8 = 3'h2;
  localparam logic [2:0] CS_DIV64 = 3'h3;
  localparam logic [2:0] CS_DIV256 = 3'h4;
  localparam logic [2:0] CS_DIV1024 = 3'h5;
  localparam logic [2:0] CS_EXT_FALL = 3'h6;
  localparam logic [2:0] CS_EXT_RISE = 3'h7;
  localparam logic [9:0] MASK_DIV8 = 10'h007;
  localparam logic [9:0] MASK_DIV64 = 10'h03f;
  localparam logic [9:0] MASK_DIV256 = 10'h0ff;
  localparam logic [9:0] MASK_DIV1024 = 10'h3ff;
  // Waveform mode class, one-hot.
  typedef enum logic [2:0] {
    CLS_NORM = 3'b001,
    CLS_FAST = 3'b010,
    CLS_PHASE = 3'b100
  } tmrwc_cls_e;
endpackage : tmrwc_pkg

// ### rtl/tmrwc_presc.sv
/*
  Prescaler: turns the clock select code into a one-cycle timer tick.
  Assumes the external count input is already synchronous to ref_clk_i.
*/
`timescale 1ns/1ps
module tmrwc_presc (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [2:0] clock_select_i,
  input wire logic ext_clk_i,
  output logic tick_o
);
  import tmrwc_pkg::*;

  logic [9:0] div_r; // Free running divider.
  logic ext_prev_r; // Previous external level for edge detection.
  logic hit; // Tick condition for this cycle.

  // The divider runs free, so a new divide ratio takes effect mid-period.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      div_r <= 10'h000;
      ext_prev_r <= 1'b0;
    end else begin
      div_r <= div_r + 10'h001;
      ext_prev_r <= ext_clk_i;
    end
  end

  // Decode the clock source choice.
  always_comb begin
    case (clock_select_i)
      CS_STOP: hit = 1'b0;
      CS_DIV1: hit = 1'b1;
      CS_DIV8: hit = (div_r & MASK_DIV8) == MASK_DIV8;
      CS_DIV64: hit = (div_r & MASK_DIV64) == MASK_DIV64;
      CS_DIV256: hit = (div_r & MASK_DIV256) == MASK_DIV256;
      CS_DIV1024: hit = div_r == MASK_DIV1024;
      CS_EXT_FALL: hit = ext_prev_r && !ext_clk_i;
      CS_EXT_RISE: hit = !ext_prev_r && ext_clk_i;
      default: hit = 1'b0;
    endcase
  end

  // The tick is registered so that it is glitch free.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tick_o <= 1'b0;
    end else begin
      tick_o <= hit;
    end
  end
endmodule : tmrwc_presc

// ### rtl/tmrwc_top.sv
/*
  Eight-bit timer with two waveform compare channels, control registers,
  counter, compare buffers and flags behind a plain register port.
  Assumes the port pins take the override enables, and that pin direction
  is set by software elsewhere.
*/
// Summary of operation
// - nonzero output mode makes output take the pin
// - channel A non-PWM: off, toggle, clear, set
// - channel A fast PWM codes with bottom actions
// - fast PWM compare at TOP: bottom action only
// - channel A phase-correct codes by count direction
// - phase-correct compare at TOP: action at TOP
// - channel B non-PWM: off, toggle, clear, set
// - channel B fast PWM, code 01 reserved
// - channel B phase-correct, code 01 reserved
// - control A bits 3 and 2 read zero
// - waveform mode selects counting and TOP source
// - compare update immediate, at TOP or BOTTOM
// - overflow flag point depends on mode
// - force strobe acts only in non-PWM modes
// - force A applies compare match to output
// - force is strobe using current output mode
// - force sets no flag, clears no counter
// - force A bit is write-only, reads zero
// - clock select chooses counter clock source
// - force B acts like force A on B
// - match flags set on match, one clears
`timescale 1ns/1ps
module tmrwc_top (
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic [tmrwc_pkg::AW-1:0] addr_i,
  input wire logic [tmrwc_pkg::DW-1:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic ext_clk_i,
  output logic [tmrwc_pkg::DW-1:0] rdata_o,
  output logic wave_out_a_o,
  output logic wave_out_b_o,
  output logic wave_ovr_a_o,
  output logic wave_ovr_b_o,
  output logic overflow_flag_o,
  output logic match_flag_a_o,
  output logic match_flag_b_o
);
  import tmrwc_pkg::*;

  // Control fields.
  logic [1:0] com_a_r; // Channel A output mode.
  logic [1:0] com_b_r; // Channel B output mode.
  logic [1:0] wgm_lo_r; // Low waveform mode bits.
  logic wgm2_r; // Waveform mode bit 2.
  logic [2:0] cs_r; // Clock select.
  // Counter state.
  logic [7:0] cnt_r; // Counter value.
  logic up_r; // Counting up in phase-correct modes.
  logic blk_r; // Match blocked after a counter write.
  logic [2:0] flags_r; // Match B, match A, overflow.
  logic [7:0] rdata_r; // Read data register.
  logic [1:0] ovr_r; // Pin override enables.
  // Per channel state, one element per channel.
  logic [7:0] cmp_buf_r [2]; // Software side compare value.
  logic [7:0] cmp_act_r [2]; // Compare value in use.
  logic wave_r [2]; // Waveform output level.
  logic m_w [2]; // Compare match this cycle.
  logic force_w [2]; // Force strobe this cycle.
  logic wr_cmp_w [2]; // Write to this channel's compare.
  // Decoded combinational values.
  logic [2:0] wgm; // Full waveform mode.
  tmrwc_cls_e cls; // Mode class.
  logic [7:0] top; // Current TOP value.
  logic at_top; // Counter is at TOP.
  logic tick; // Timer clock enable.
  logic nxt_up; // Direction for the next phase-correct step.
  logic tov_ev; // Overflow event.
  logic wrap_ev; // Fast PWM wrap from TOP to BOTTOM.
  logic top_ev; // Phase-correct turn at TOP.
  logic upd; // Load buffered compare values.
  logic wr_ca, wr_cb, wr_cnt, wr_fl; // Write decodes.

  assign wr_ca = wr_i && (addr_i == ADDR_CTRL_A);
  assign wr_cb = wr_i && (addr_i == ADDR_CTRL_B);
  assign wr_cnt = wr_i && (addr_i == ADDR_COUNT);
  assign wr_fl = wr_i && (addr_i == ADDR_FLAGS);
  assign wr_cmp_w[0] = wr_i && (addr_i == ADDR_CMP_A);
  assign wr_cmp_w[1] = wr_i && (addr_i == ADDR_CMP_B);
  assign wgm = {wgm2_r, wgm_lo_r};

  // Timer clock enable from the prescaler.
  tmrwc_presc u_presc (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .clock_select_i(cs_r),
    .ext_clk_i(ext_clk_i),
    .tick_o(tick)
  );

  // Mode class and TOP source. Reserved modes 4 and 6 count as normal.
  always_comb begin
    case (wgm)
      WGM_PHASE_FF, WGM_PHASE_CA: cls = CLS_PHASE;
      WGM_FAST_FF, WGM_FAST_CA: cls = CLS_FAST;
      default: cls = CLS_NORM;
    endcase
    if (wgm == WGM_CTC || wgm == WGM_PHASE_CA || wgm == WGM_FAST_CA) begin
      top = cmp_act_r[0];
    end else begin
      top = MAX_VAL;
    end
  end

  assign at_top = cnt_r == top;
  assign nxt_up = up_r ? !at_top : (cnt_r == BOTTOM_VAL);
  assign wrap_ev = tick && at_top && (cls == CLS_FAST);
  assign top_ev = tick && at_top && up_r && (cls == CLS_PHASE);
  // Buffered compare values load at BOTTOM or at TOP.
  assign upd = wrap_ev || top_ev;

  // Overflow point per mode.
  always_comb begin
    if (cls == CLS_PHASE) begin
      tov_ev = tick && !up_r && (cnt_r == BOTTOM_VAL);
    end else if (wgm == WGM_FAST_CA) begin
      tov_ev = tick && at_top;
    end else begin
      tov_ev = tick && (cnt_r == MAX_VAL);
    end
  end

  // Control registers. Force bits are never stored, they only strobe.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      com_a_r <= CTRL_A_RST[CA_COMA_LSB +: 2];
      com_b_r <= CTRL_A_RST[CA_COMB_LSB +: 2];
      wgm_lo_r <= CTRL_A_RST[CA_WGM_LSB +: 2];
      wgm2_r <= CTRL_B_RST[CB_WGM2_BIT];
      cs_r <= CTRL_B_RST[CB_CS_LSB +: 3];
    end else begin
      if (wr_ca) begin
        com_a_r <= wdata_i[CA_COMA_LSB +: 2];
        com_b_r <= wdata_i[CA_COMB_LSB +: 2];
        wgm_lo_r <= wdata_i[CA_WGM_LSB +: 2];
      end
      if (wr_cb) begin
        wgm2_r <= wdata_i[CB_WGM2_BIT];
        cs_r <= wdata_i[CB_CS_LSB +: 3];
      end
    end
  end

  // Counter: single slope in normal and fast modes, dual slope in phase-correct.
  // A forced compare never touches it, so it never clears it early.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_r <= CNT_RST;
      up_r <= 1'b1;
    end else if (wr_cnt) begin
      cnt_r <= wdata_i;
    end else if (tick) begin
      if (cls == CLS_PHASE) begin
        up_r <= nxt_up;
        cnt_r <= nxt_up ? cnt_r + 8'h01 : cnt_r - 8'h01;
      end else begin
        up_r <= 1'b1;
        cnt_r <= at_top ? BOTTOM_VAL : cnt_r + 8'h01;
      end
    end
  end

  // A counter write suppresses the match on the next timer tick.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      blk_r <= 1'b0;
    end else if (wr_cnt) begin
      blk_r <= 1'b1;
    end else if (tick) begin
      blk_r <= 1'b0;
    end
  end

  // Flags: write one clears, a new event in the same cycle wins.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flags_r <= FLAGS_RST;
    end else begin
      flags_r <= (flags_r & ~(wr_fl ? wdata_i[2:0] : 3'h0))
        | {m_w[1], m_w[0], tov_ev};
    end
  end

  // Override enables track the output mode fields.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ovr_r <= 2'h0;
    end else begin
      ovr_r <= {|com_b_r, |com_a_r};
    end
  end

  // Read data stand only in the cycle after the read strobe.
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_r <= 8'h00;
    end else if (rd_i) begin
      case (addr_i)
        ADDR_CTRL_A: rdata_r <= {com_a_r, com_b_r, 2'h0, wgm_lo_r};
        ADDR_CTRL_B: rdata_r <= {4'h0, wgm2_r, cs_r};
        ADDR_COUNT: rdata_r <= cnt_r;
        ADDR_CMP_A: rdata_r <= cmp_buf_r[0];
        ADDR_CMP_B: rdata_r <= cmp_buf_r[1];
        ADDR_FLAGS: rdata_r <= {5'h00, flags_r};
        default: rdata_r <= 8'h00;
      endcase
    end else begin
      rdata_r <= 8'h00;
    end
  end

  assign rdata_o = rdata_r;
  assign wave_out_a_o = wave_r[0];
  assign wave_out_b_o = wave_r[1];
  assign wave_ovr_a_o = ovr_r[0];
  assign wave_ovr_b_o = ovr_r[1];
  assign overflow_flag_o = flags_r[FL_TOV_BIT];
  assign match_flag_a_o = flags_r[FL_MA_BIT];
  assign match_flag_b_o = flags_r[FL_MB_BIT];

  // One compare channel per iteration; channel 0 is A, channel 1 is B.
  for (genvar g = 0; g < 2; g++) begin : gen_ch
    logic [1:0] com; // This channel's output mode.
    logic special; // Compare equals TOP with upper mode bit set.
    logic tog_ok; // Toggle allowed in this mode.
    assign com = (g == 0) ? com_a_r : com_b_r;
    assign special = com[1] && (cmp_act_r[g] == top);
    // Toggle in PWM modes exists only on A with mode bit 2 set.
    assign tog_ok = (com == COM_TOGGLE) && ((cls == CLS_NORM) || (g == 0 && wgm2_r));
    // Match on each timer tick against the active value.
    assign m_w[g] = tick && !blk_r && (cnt_r == cmp_act_r[g]);
    // Force strobe, taken only in non-PWM modes.
    assign force_w[g] = wr_cb && wdata_i[(g == 0) ? CB_FOCA_BIT : CB_FOCB_BIT]
      && (cls == CLS_NORM);

    // Software side compare value.
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        cmp_buf_r[g] <= CMP_RST;
      end else if (wr_cmp_w[g]) begin
        cmp_buf_r[g] <= wdata_i;
      end
    end

    // Active value: immediate in non-PWM, double buffered in PWM.
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        cmp_act_r[g] <= CMP_RST;
      end else if (cls == CLS_NORM) begin
        cmp_act_r[g] <= wr_cmp_w[g] ? wdata_i : cmp_buf_r[g];
      end else if (upd) begin
        cmp_act_r[g] <= cmp_buf_r[g];
      end
    end

    // Waveform generator. The reserved code 01 on B in PWM does nothing.
    always_ff @(posedge ref_clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
        wave_r[g] <= 1'b0;
      end else begin
        case (cls)
          CLS_NORM: begin
            // Match or forced match, decided by the present mode.
            if (m_w[g] || force_w[g]) begin
              case (com)
                COM_TOGGLE: wave_r[g] <= !wave_r[g];
                COM_CLEAR: wave_r[g] <= 1'b0;
                COM_SET: wave_r[g] <= 1'b1;
                default: wave_r[g] <= wave_r[g];
              endcase
            end
          end
          CLS_FAST: begin
            if (m_w[g] && !special) begin
              // Match action of fast PWM.
              if (tog_ok) begin
                wave_r[g] <= !wave_r[g];
              end else if (com[1]) begin
                wave_r[g] <= com[0];
              end
            end else if (wrap_ev && com[1]) begin
              // Bottom action, the only one when compare is TOP.
              wave_r[g] <= !com[0];
            end
          end
          CLS_PHASE: begin
            if (special) begin
              // Compare at TOP: match ignored, level set at TOP.
              if (top_ev) begin
                wave_r[g] <= !com[0];
              end
            end else if (m_w[g]) begin
              // Up-count match clears for 10, down-count sets.
              if (tog_ok) begin
                wave_r[g] <= !wave_r[g];
              end else if (com[1]) begin
                wave_r[g] <= up_r ? com[0] : !com[0];
              end
            end
          end
          default: wave_r[g] <= wave_r[g];
        endcase
      end
    end

    // Checks on this channel.
    sequence s_norm_clr;
      (cls == CLS_NORM) && m_w[g] && (com == COM_CLEAR);
    endsequence
    sequence s_clr_and_hit;
      wr_fl && wdata_i[g + 1] && m_w[g];
    endsequence

    a_norm_clear: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      s_norm_clr |=> !wave_r[g])
      else $error("non-PWM clear code did not clear output");
    a_norm_toggle: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      ((cls == CLS_NORM) && (m_w[g] || force_w[g]) && com == COM_TOGGLE)
      |=> (wave_r[g] != $past(wave_r[g])))
      else $error("toggle code did not toggle output");
    a_fast_bottom: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (wrap_ev && !m_w[g] && com == COM_CLEAR) |=> wave_r[g])
      else $error("fast PWM did not set output at bottom");
    a_fast_special: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      ((cls == CLS_FAST) && special && m_w[g] && wrap_ev && com == COM_SET)
      |=> !wave_r[g])
      else $error("fast PWM match at TOP was not ignored");
    a_phase_up: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      ((cls == CLS_PHASE) && m_w[g] && !special && up_r && com == COM_CLEAR)
      ##1 ((cls == CLS_PHASE) && !m_w[g] && !top_ev) [*2]
      |-> !wave_r[g])
      else $error("phase-correct up match did not clear output");
    a_phase_top: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      ((cls == CLS_PHASE) && special && top_ev && com == COM_CLEAR)
      |=> wave_r[g])
      else $error("phase-correct compare at TOP did not set output");
    a_force_pwm: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (wr_cb && wdata_i[(g == 0) ? CB_FOCA_BIT : CB_FOCB_BIT]
        && (cls != CLS_NORM) && !tick) |=> $stable(wave_r[g]))
      else $error("force strobe acted in a PWM mode");
    a_force_noflag: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (force_w[g] && !m_w[g]) |=> $stable(flags_r[g + 1]))
      else $error("forced compare changed a match flag");
    a_flag_wins: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      s_clr_and_hit |=> flags_r[g + 1])
      else $error("match lost against a flag clear");
    a_cmp_buffered: assert property (
      @(posedge ref_clk_i) disable iff (!nrst_i)
      (wr_cmp_w[g] && (cls != CLS_NORM) && !upd) |=> $stable(cmp_act_r[g]))
      else $error("PWM compare value updated without buffering");
  end

  // Checks on shared logic.
  a_ovr_follow: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    ##1 (wave_ovr_a_o == $past(|com_a_r)) && (wave_ovr_b_o == $past(|com_b_r)))
    else $error("pin override does not follow output mode");
  a_rsvd_zero: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (rd_i && (addr_i == ADDR_CTRL_A || addr_i == ADDR_CTRL_B))
    |=> (rdata_o[3:2] == 2'h0 || $past(addr_i) != ADDR_CTRL_A)
      && (rdata_o[7:4] == 4'h0 || $past(addr_i) != ADDR_CTRL_B))
    else $error("reserved or force bits did not read zero");
  a_ovf_flag: assert property (
    @(posedge ref_clk_i) disable iff (!nrst_i)
    (tick && (wgm == WGM_NORMAL) && cnt_r == MAX_VAL && !wr_cnt)
    |=> overflow_flag_o && cnt_r == BOTTOM_VAL)
    else $error("normal mode overflow not flagged at MAX");
endmodule : tmrwc_top

// ### sim/tmrwc_pin_model.sv
/*
  Port pin model standing behind one waveform output of the timer.
  Assumes the direction bit and the ordinary port value come from the bench.
*/
`timescale 1ns/1ps
module tmrwc_pin_model (
  input wire logic wave_i,
  input wire logic ovr_i,
  input wire logic dir_i,
  input wire logic port_i,
  output logic pad_o
);
  // The pad is driven only while the direction bit selects output.
  always_comb begin
    if (!dir_i) begin
      pad_o = 1'b1; // Driver off, so the external pull-up wins.
    end else begin
      pad_o = ovr_i ? wave_i : port_i; // Waveform replaces the port value.
    end
  end
endmodule : tmrwc_pin_model

// ### sim/testbench.sv
/*
  Self-checking bench for the timer waveform compare block.
  Assumes the package offsets and the one-cycle register port of the block.
*/
`timescale 1ns/1ps
module testbench;
  import tmrwc_pkg::*;
  logic ref_clk = 1'b0; // 10 MHz clock.
  logic nrst = 1'b0; // Active-low reset.
  logic [7:0] addr = 8'h00; // Register address.
  logic [7:0] wdata = 8'h00; // Write data.
  logic wr = 1'b0; // Write strobe.
  logic rd = 1'b0; // Read strobe.
  logic dir = 1'b0; // Pin direction bit, owned by software.
  logic ext_clk = 1'b0; // External count input, toggled by the bench.
  logic [7:0] rdata; // Read data from the block.
  logic wa, wb, oa, ob, ovf, ma, mb, pad_a, pad_b; // Observed outputs.
  int errors = 0; // Mismatch count.
  int tests_run = 0; // Comparison count.
  logic [7:0] fa [3] = '{8'hf0, 8'ha0, 8'h50}; // Set, clear, toggle on both.
  logic [1:0] fe [3] = '{2'b11, 2'b00, 2'b11}; // Levels after each force.

  // Half-period inversion gives the 100 ns period.
  always #50 ref_clk = ~ref_clk;

  // The external count input stays low except in the edge counting scenario.
  tmrwc_top u_dut (.ref_clk_i(ref_clk), .nrst_i(nrst), .addr_i(addr), .wdata_i(wdata),
    .wr_i(wr), .rd_i(rd), .ext_clk_i(ext_clk), .rdata_o(rdata), .wave_out_a_o(wa),
    .wave_out_b_o(wb), .wave_ovr_a_o(oa), .wave_ovr_b_o(ob), .overflow_flag_o(ovf),
    .match_flag_a_o(ma), .match_flag_b_o(mb));
  tmrwc_pin_model u_pin_a (.wave_i(wa), .ovr_i(oa), .dir_i(dir), .port_i(1'b0),
    .pad_o(pad_a));
  tmrwc_pin_model u_pin_b (.wave_i(wb), .ovr_i(ob), .dir_i(dir), .port_i(1'b0),
    .pad_o(pad_b));

  // Prints the counts and the verdict, then stops the run.
  task automatic give_verdict;
    $display("errors %0d comparisons %0d", errors, tests_run);
    if (errors == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : give_verdict

  // Compares with case equality so an unknown never passes.
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  // One-cycle write; an edge passes first so strobes never collide.
  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge ref_clk);
    wr <= 1'b0;
  endtask : reg_wr

  // One-cycle read; data stand only in the cycle after the strobe edge.
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
    @(posedge ref_clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge ref_clk);
    rd <= 1'b0;
    #1;
    check(rdata, exp);
  endtask : rd_chk

  // Lets n edges pass, then steps off the edge so outputs are settled.
  task automatic settle(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : settle

  // Bounded wait for the match A flag or the overflow flag.
  task automatic wait_hi(input bit sel_ovf);
    int k;
    for (k = 0; k < 700; k++) begin
      settle(1);
      if ((sel_ovf ? ovf : ma) === 1'b1) break;
    end
    if (k == 700) begin
      errors++;
      give_verdict();
    end
  endtask : wait_hi

  // One counting run from zero with both compares at cv: outputs are
  // checked after the first match, then after overflow or the next match.
  task automatic run_mode(input logic [7:0] ca, input logic [7:0] cv, input bit second_ovf,
                          input logic [1:0] exp1, input logic [1:0] exp2);
    reg_wr(ADDR_CTRL_B, 8'h00);
    reg_wr(ADDR_CTRL_A, 8'h00);
    reg_wr(ADDR_COUNT, 8'h00);
    reg_wr(ADDR_CMP_A, cv);
    reg_wr(ADDR_CMP_B, cv);
    reg_wr(ADDR_FLAGS, 8'h07);
    reg_wr(ADDR_CTRL_A, ca);
    reg_wr(ADDR_CTRL_B, {5'h00, CS_DIV1}); // Force bits stay zero in PWM.
    wait_hi(1'b0);
    settle(2);
    check({6'h00, wa, wb}, {6'h00, exp1});
    check({6'h00, mb, ma}, 8'h03);
    reg_wr(ADDR_FLAGS, 8'h07);
    wait_hi(second_ovf);
    settle(2);
    check({6'h00, wa, wb}, {6'h00, exp2});
    check({6'h00, pad_a, pad_b}, {6'h00, exp2});
  endtask : run_mode

  // Main sequence: reset, register map, forced matches, then counting runs.
  initial begin
    repeat (12) @(posedge ref_clk);
    nrst <= 1'b1;
    rd_chk(ADDR_CTRL_A, CTRL_A_RST);
    rd_chk(ADDR_CTRL_B, CTRL_B_RST);
    rd_chk(ADDR_FLAGS, 8'h00);
    rd_chk(8'h3c, 8'h00);
    reg_wr(ADDR_CTRL_A, 8'hff);
    rd_chk(ADDR_CTRL_A, 8'hf3);
    // Mode 7 with the external source stopped: the force must be ignored.
    reg_wr(ADDR_CTRL_B, 8'hcf);
    rd_chk(ADDR_CTRL_B, 8'h0f);
    check({6'h00, wa, wb}, 8'h00);
    reg_wr(ADDR_CTRL_B, 8'h00);
    // Set, clear and toggle codes, applied by the force strobe with the counter stopped.
    for (int i = 0; i < 3; i++) begin
      reg_wr(ADDR_CTRL_A, fa[i]);
      reg_wr(ADDR_CTRL_B, 8'hc0);
      settle(1);
      check({6'h00, wa, wb}, {6'h00, fe[i]});
    end
    check({6'h00, oa, ob}, 8'h03);
    check({5'h00, mb, ma, ovf}, 8'h00);
    dir <= 1'b1;
    settle(1);
    check({6'h00, pad_a, pad_b}, 8'h03);
    // Fast PWM with clear code: the force must leave both levels high.
    reg_wr(ADDR_CTRL_A, 8'ha3);
    reg_wr(ADDR_CTRL_B, 8'hc0);
    settle(1);
    check({6'h00, wa, wb}, 8'h03);
    reg_wr(ADDR_CTRL_A, 8'h03);
    settle(2);
    check({6'h00, oa, ob}, 8'h00);
    run_mode(8'h60, 8'h80, 1'b1, 2'b00, 2'b00);
    run_mode(8'hb3, 8'h80, 1'b1, 2'b01, 2'b10);
    // Compare at TOP in the first two runs: the match is ignored and only the TOP or BOTTOM action runs.
    run_mode(8'hf3, 8'hff, 1'b1, 2'b00, 2'b00);
    run_mode(8'he1, 8'hff, 1'b1, 2'b01, 2'b01);
    run_mode(8'he1, 8'h80, 1'b0, 2'b10, 2'b01);
    // External rising edges: three of them must advance the counter by three.
    reg_wr(ADDR_CTRL_B, 8'h00);
    reg_wr(ADDR_CTRL_A, 8'h00);
    reg_wr(ADDR_COUNT, 8'h00);
    reg_wr(ADDR_CTRL_B, {5'h00, CS_EXT_RISE});
    repeat (6) begin
      repeat (2) @(posedge ref_clk);
      ext_clk <= ~ext_clk;
    end
    rd_chk(ADDR_COUNT, 8'h03);
    give_verdict();
  end
endmodule : testbench
